// [rtl/its_time_hk.sv]
`timescale 1ns/10ps
module its_time_hk
    import its_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // time update command, one-cycle strobe with header and time
    input wire logic tc_valid,
    input wire its_tc_hdr_t tc_hdr,
    input wire its_cuc_t tc_time,
    // broadcast sync
    input wire logic sync_pulse,
    // housekeeping control
    input wire logic hk_enable,
    // housekeeping packet words from collection
    input wire logic hk_valid,
    input wire logic [ITS_HK_W-1:0] hk_data,
    // outbound queue
    output logic tm_valid,
    output logic [ITS_HK_W-1:0] tm_data,
    input wire logic tm_ready,
    // time and queue status
    output its_cuc_t stamp,
    output logic pending,
    output logic tc_reject,
    output logic fifo_full
);

    // ----------------------------------------------------------------
    // command acceptance
    // ----------------------------------------------------------------
    // header check only; sequence count low bits are not tracked here
    wire logic hdr_ok =
        tc_hdr.version == ITS_VERSION && tc_hdr.pkt_type && tc_hdr.hdr_flag
        && tc_hdr.proc_id == ITS_PROC_ID && tc_hdr.category == ITS_CATEGORY
        && tc_hdr.seq_flags == ITS_SEQ_FLAGS
        && tc_hdr.seq_count[13:11] == ITS_SEQ_SRC
        && tc_hdr.pkt_len == ITS_TU_LEN
        && tc_hdr.pus_version == ITS_VERSION && tc_hdr.cksum_flag
        && tc_hdr.ack == ITS_ACK_CODE && tc_hdr.svc_type == ITS_SVC_TYPE
        && tc_hdr.svc_sub == ITS_SVC_SUB && tc_hdr.pad == ITS_PAD;
    wire logic tc_accept = tc_valid && hdr_ok;

    // ----------------------------------------------------------------
    // pending time and reference
    // ----------------------------------------------------------------
    its_cuc_t held_ff;
    its_cuc_t ref_ff;
    logic pend_ff;
    logic rej_ff;
    // a pulse in the same cycle as a command adopts the older held value if one is pending, else nothing
    wire logic adopt = sync_pulse && pend_ff;
    wire logic nxt_pend = tc_accept || (pend_ff && !sync_pulse);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            held_ff <= ITS_CUC_RST;
            ref_ff <= ITS_CUC_RST;
            pend_ff <= 1'b0;
            rej_ff <= 1'b0;
        end
        else
        begin
            if (tc_accept)
                held_ff <= tc_time;
            if (adopt)
                ref_ff <= held_ff;
            pend_ff <= nxt_pend;
            rej_ff <= tc_valid && !hdr_ok;
        end
    end

    // ----------------------------------------------------------------
    // elapsed-time counter at 1/65536 s
    // ----------------------------------------------------------------
    // phase accumulator gives exact average rate, jitter under one tick
    // no saturation: the hourly update keeps the count far from wrap
    logic [23:0] ph_ff;
    its_cuc_t elap_ff;
    wire logic [23:0] ph_sum = ph_ff + ITS_PH_INC;
    wire logic tick = ph_sum >= ITS_PH_MOD;
    wire logic [23:0] nxt_ph = tick ? ph_sum - ITS_PH_MOD : ph_sum;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_ff <= ITS_PH_RST;
            elap_ff <= ITS_CUC_RST;
        end
        else if (adopt)
        begin
            ph_ff <= ITS_PH_RST;
            elap_ff <= ITS_CUC_RST;
        end
        else
        begin
            ph_ff <= nxt_ph;
            if (tick)
                elap_ff <= elap_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // timestamp
    // ----------------------------------------------------------------
    its_cuc_t stamp_ff;
    wire its_cuc_t nxt_stamp = ref_ff + elap_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            stamp_ff <= ITS_CUC_RST;
        else
            stamp_ff <= nxt_stamp;
    end

    assign stamp = stamp_ff;
    assign pending = pend_ff;
    assign tc_reject = rej_ff;

    // ----------------------------------------------------------------
    // housekeeping gate
    // ----------------------------------------------------------------
    // words are always consumed; disabled words are simply not written
    // no ready back to collection, so its cycle never waits on the gate
    logic fifo_in_ready;
    wire logic gate_wr = hk_valid && hk_enable;
    logic full_ff;

    its_fifo #(
        .WIDTH(ITS_HK_W),
        .DEPTH(ITS_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(gate_wr),
        .in_data(hk_data),
        .in_ready(fifo_in_ready),
        .out_valid(tm_valid),
        .out_data(tm_data),
        .out_ready(tm_ready)
    );

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            full_ff <= 1'b0;
        else
            full_ff <= !fifo_in_ready;
    end

    assign fifo_full = full_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_adopt_ref: assert property (adopt |=> ref_ff == $past(held_ff))
        else $error("reference not adopted on sync");
    chk_clear_elap: assert property (adopt |=> elap_ff == '0)
        else $error("elapsed counter not cleared");
    chk_stamp_sum: assert property (##1 stamp == $past(ref_ff) + $past(elap_ff))
        else $error("stamp is not reference plus elapsed");
    chk_tick_rate: assert property (tick |=> !tick [*8])
        else $error("ticks too close together");
    chk_tick_bound: assert property (!adopt [*1] ##1 1 |-> ##[0:153] tick or adopt)
        else $error("no tick within bound");
    chk_no_pend_hold: assert property
        (sync_pulse && !pend_ff |=> ref_ff == $past(ref_ff))
        else $error("reference changed without pending update");
    chk_pend_set: assert property (tc_accept |=> pend_ff)
        else $error("update not held pending");
    chk_hold_value: assert property (tc_accept |=> held_ff == $past(tc_time))
        else $error("held time differs from command");
    // queue checks watch its own ready and valid; chk_hk_pass also starts from the gate term hk_valid && hk_enable
    chk_hk_drop: assert property (!hk_enable && fifo_in_ready |=> fifo_in_ready)
        else $error("disabled hk word entered queue");
    chk_hk_pass: assert property (hk_valid && hk_enable && !tm_valid |-> ##[1:2] tm_valid)
        else $error("enabled hk word not queued");
    chk_pend_clear: assert property (adopt && !tc_accept |=> !pending)
        else $error("pending not cleared by sync");
    chk_elap_hold: assert property (!adopt && !tick |=> elap_ff == $past(elap_ff))
        else $error("elapsed counter moved without tick");
    chk_elap_step: assert property (!adopt && tick |=> elap_ff == $past(elap_ff) + 1'b1)
        else $error("elapsed counter missed a tick");
    chk_full_flag: assert property (!fifo_in_ready |=> fifo_full)
        else $error("full flag not raised");
    chk_reject_pulse: assert property (!tc_valid |=> !tc_reject)
        else $error("reject without command");
    chk_bad_hdr: assert property (tc_valid && !hdr_ok |=> tc_reject && held_ff == $past(held_ff))
        else $error("bad header not rejected");

    cov_update_sync: cover property (tc_accept ##[1:20] adopt);
    cov_double_update: cover property (tc_accept ##1 tc_accept ##[1:5] adopt);
    cov_fifo_full: cover property (!fifo_in_ready);
    cov_hk_drop: cover property (hk_valid && !hk_enable);
    cov_idle_pulse: cover property (sync_pulse && !pend_ff);

endmodule : its_time_hk

// [rtl/its_pkg.sv]
package its_pkg;

    // ----------------------------------------------------------------
    // time formats
    // ----------------------------------------------------------------
    localparam int unsigned ITS_SEC_W = 32;
    localparam int unsigned ITS_FRAC_W = 16;
    localparam int unsigned ITS_CUC_W = ITS_SEC_W + ITS_FRAC_W;
    localparam logic [ITS_CUC_W-1:0] ITS_CUC_RST = 48'h0;

    // ----------------------------------------------------------------
    // clock and fractional tick
    // ----------------------------------------------------------------
    localparam int unsigned ITS_CLK_HZ = 10000000;
    localparam int unsigned ITS_FRAC_HZ = 65536;
    // phase accumulator: add FRAC_HZ each clock, tick on wrap of CLK_HZ
    localparam logic [23:0] ITS_PH_INC = 24'(ITS_FRAC_HZ);
    localparam logic [23:0] ITS_PH_MOD = 24'(ITS_CLK_HZ);
    localparam logic [23:0] ITS_PH_RST = 24'h0;

    // ----------------------------------------------------------------
    // time update command fields
    // ----------------------------------------------------------------
    localparam logic [2:0] ITS_VERSION = 3'h0;
    localparam logic [6:0] ITS_PROC_ID = 7'h47;
    localparam logic [3:0] ITS_CATEGORY = 4'hc;
    localparam logic [1:0] ITS_SEQ_FLAGS = 2'h3;
    localparam logic [2:0] ITS_SEQ_SRC = 3'h0;
    localparam logic [15:0] ITS_LEN_OFFSET = 16'h5;
    localparam logic [15:0] ITS_TU_LEN = 16'h7;
    localparam logic [3:0] ITS_ACK_CODE = 4'h1;
    localparam logic [7:0] ITS_SVC_TYPE = 8'h09;
    localparam logic [7:0] ITS_SVC_SUB = 8'h01;
    localparam logic [7:0] ITS_PAD = 8'h00;

    // ----------------------------------------------------------------
    // housekeeping path
    // ----------------------------------------------------------------
    localparam int unsigned ITS_HK_W = 16;
    localparam int unsigned ITS_FIFO_DEPTH = 16;

    typedef struct packed {
        logic [2:0] version;
        logic pkt_type;
        logic hdr_flag;
        logic [6:0] proc_id;
        logic [3:0] category;
        logic [1:0] seq_flags;
        logic [13:0] seq_count;
        logic [15:0] pkt_len;
        logic [2:0] pus_version;
        logic cksum_flag;
        logic [3:0] ack;
        logic [7:0] svc_type;
        logic [7:0] svc_sub;
        logic [7:0] pad;
    } its_tc_hdr_t;

    typedef struct packed {
        logic [ITS_SEC_W-1:0] sec;
        logic [ITS_FRAC_W-1:0] frac;
    } its_cuc_t;

endpackage : its_pkg

// [rtl/its_fifo.sv]
`timescale 1ns/10ps
module its_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic [WIDTH-1:0] rdata_ff;
    logic rvalid_ff;

    wire logic [AW:0] used = wr_ptr_ff - rd_ptr_ff;
    wire logic mem_full = (used == (AW+1)'(DEPTH));
    wire logic mem_empty = (used == '0);
    // output register refills when empty or being taken
    wire logic take_out = rvalid_ff && out_ready;
    wire logic load_out = !mem_empty && (!rvalid_ff || take_out);
    wire logic do_wr = in_valid && !mem_full;

    assign in_ready = !mem_full;
    assign out_valid = rvalid_ff;
    assign out_data = rdata_ff;

    always_ff @(posedge sys_clk)
    begin
        if (do_wr)
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            if (do_wr)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (load_out)
            begin
                rdata_ff <= mem_ff[rd_ptr_ff[AW-1:0]];
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                rvalid_ff <= 1'b1;
            end
            else if (take_out)
                rvalid_ff <= 1'b0;
        end
    end

endmodule : its_fifo

// [verif/its_sc_model.sv]
`timescale 1ns/10ps
module its_sc_model
    import its_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // command and sync toward the instrument
    output logic tc_valid,
    output its_tc_hdr_t tc_hdr,
    output its_cuc_t tc_time,
    output logic sync_pulse
);
    logic [10:0] seq_ff;

    initial
    begin
        tc_valid = 1'b0;
        tc_hdr = '0;
        tc_time = '0;
        sync_pulse = 1'b0;
        seq_ff = 11'h0;
    end

    // ------------------------------------------------------------
    // command sender; flip >= 0 corrupts that header bit on purpose
    // ------------------------------------------------------------
    task automatic send(input logic [47:0] t, input int flip);
        @(negedge sys_clk);
        tc_valid = 1'b1;
        tc_hdr = {3'h0, 1'b1, 1'b1, 7'h47, 4'hc,
                  2'h3, 3'h0, seq_ff,
                  16'h0007,
                  3'h0, 1'b1, 4'h1, 8'h09, 8'h01, 8'h00};
        if (flip >= 0)
            tc_hdr[flip] = ~tc_hdr[flip];
        tc_time = t;
        seq_ff = seq_ff + 11'h1;
        @(negedge sys_clk);
        tc_valid = 1'b0;
        // released lines must not keep showing the old value
        tc_hdr = ~tc_hdr;
        tc_time = ~tc_time;
    endtask : send

    task automatic pulse();
        @(negedge sys_clk);
        sync_pulse = 1'b1;
        @(negedge sys_clk);
        sync_pulse = 1'b0;
    endtask : pulse
endmodule : its_sc_model

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench
    import its_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hk_enable, hk_valid, tm_ready, tm_valid, pending, tc_reject, fifo_full;
    logic [15:0] hk_data, tm_data;
    logic tc_valid, sync_pulse;
    its_tc_hdr_t tc_hdr;
    its_cuc_t tc_time, stamp;
    int n_fail = 0;
    int samples_checked = 0;
    int seed, flip;
    longint cyc, t0;
    logic [47:0] ref_e, held_e;
    bit pend_e;
    logic [15:0] q[$];

    always #50 sys_clk = ~sys_clk;

    its_sc_model sc (.sys_clk, .tc_valid, .tc_hdr, .tc_time, .sync_pulse);
    its_time_hk i_its_time_hk (.sys_clk, .rst_n, .tc_valid, .tc_hdr, .tc_time,
        .sync_pulse, .hk_enable, .hk_valid, .hk_data, .tm_valid, .tm_data,
        .tm_ready, .stamp, .pending, .tc_reject, .fifo_full);

    // ------------------------------------------------------------
    // checks and verdict
    // ------------------------------------------------------------
    task automatic check_val(input string name, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    // one tick of slack: stamp lags a cycle and the tick phase is free
    task automatic check_stamp();
        logic [47:0] exp, d;
        exp = ref_e + 48'((cyc - t0) * 65536 / 10000000);
        d = stamp - exp;
        samples_checked++;
        if (d !== 48'h0 && d !== 48'h1 && d !== 48'hffffffffffff)
        begin
            n_fail++;
            $display("ERROR stamp expected %h seen %h", exp, stamp);
        end
    endtask : check_stamp

    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // reference model, sampled on the design's edge
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rst_n)
        begin
            if (sync_pulse && pend_e)
            begin
                ref_e = held_e;
                t0 = cyc;
                pend_e = 0;
            end
            if (tc_valid && (flip < 0 || (flip >= 48 && flip <= 58)))
            begin
                held_e = tc_time;
                pend_e = 1;
            end
            // a full queue refuses even when its head leaves at this edge
            if (hk_valid && hk_enable && q.size() < 17)
                q.push_back(hk_data);
            if (tm_valid && tm_ready)
                check_val("tm_data", (q.size() > 0) ? {32'h0, q.pop_front()} : 48'h1_0000, {32'h0, tm_data});
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h4b888dcb;
        {hk_enable, hk_valid, tm_ready, hk_data} = '0;
        {ref_e, held_e, pend_e} = '0;
        cyc = 0;
        t0 = 10;
        flip = -1;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (300) @(negedge sys_clk);
        check_stamp();
        sc.send({$random(seed), 16'h8000}, -1);
        check_val("pending", 1, pending);
        check_stamp();
        sc.pulse();
        check_val("pending", 0, pending);
        repeat (2) @(negedge sys_clk);
        check_stamp();
        repeat (2000) @(negedge sys_clk);
        check_stamp();
        sc.send(48'h0000_1111_0000, -1);
        sc.send({$random(seed), 16'hffff}, -1);
        sc.pulse();
        repeat (2) @(negedge sys_clk);
        check_stamp();
        sc.pulse();
        repeat (500) @(negedge sys_clk);
        check_stamp();
        for (int i = 0; i < $bits(its_tc_hdr_t); i++)
        begin
            flip = i;
            sc.send(48'(i * 7), i);
            check_val("tc_reject", (i >= 48 && i <= 58) ? 48'h0 : 48'h1, {47'h0, tc_reject});
            check_val("pending", {47'h0, pend_e}, {47'h0, pending});
        end
        flip = -1;
        sc.pulse();
        repeat (2) @(negedge sys_clk);
        check_stamp();
        repeat (8)
        begin
            hk_valid = 1'b1;
            hk_data = 16'($random(seed));
            @(negedge sys_clk);
        end
        hk_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        check_val("tm_valid", 0, {47'h0, tm_valid});
        hk_enable = 1'b1;
        repeat (20)
        begin
            hk_valid = 1'b1;
            hk_data = 16'($random(seed));
            @(negedge sys_clk);
            hk_valid = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        check_val("fifo_full", 1, {47'h0, fifo_full});
        repeat (400)
        begin
            hk_valid = (($random(seed) & 3) == 0);
            hk_enable = (($random(seed) & 7) != 0);
            hk_data = 16'($random(seed));
            tm_ready = 1'($random(seed));
            @(negedge sys_clk);
        end
        hk_valid = 1'b0;
        tm_ready = 1'b1;
        repeat (40) @(negedge sys_clk);
        check_val("queue_left", 0, 48'(q.size()));
        check_val("tm_valid", 0, {47'h0, tm_valid});
        end_of_test();
    end

    initial
    begin
        #(20000 * 100);
        n_fail++;
        end_of_test();
    end
endmodule : testbench
